//--- common/bmc_pkg.sv
// bmc_pkg: constants for the basic mode control register block
// assumes a 50 MHz management-domain clock
package bmc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_BASIC_MODE_CONTROL = 5'h00;
	localparam int BIT_RESET = 15;
	localparam int BIT_LOOPBACK = 14;
	localparam int BIT_SPEED = 13;
	localparam int BIT_AN_ENABLE = 12;
	localparam int BIT_POWER_DOWN = 11;
	localparam int BIT_ISOLATE = 10;
	localparam int BIT_AN_RESTART = 9;
	localparam int BIT_DUPLEX = 8;
	localparam int BIT_COL_TEST = 7;
	localparam logic [15:0] WRITE_MASK = 16'hff80;
	// ----------------------------------------------------------------
	// reset values (duplex comes from strap)
	// ----------------------------------------------------------------
	localparam logic [15:0] RESET_VALUE = 16'h3000;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SOFT_RESET_NS = 1000;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// collision test: 4 bit times at 10 Mb/s is 400 ns, longest time rounds down
	localparam int COL_OFF_NS = 400;
	localparam int COL_OFF_CYCLES = COL_OFF_NS / CLK_PERIOD_NS;
endpackage

//--- verilog/bmc_sync.sv
// bmc_sync: two-flop synchroniser for one level
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ps
module bmc_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic en_i,
	// level
	input wire logic async_i,
	output logic sync_o
);
	logic meta;
	logic next_meta;
	logic next_sync;

	always_comb begin
		next_meta = en_i ? async_i : meta;
		next_sync = en_i ? meta : sync_o;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta <= RESET_LEVEL;
			sync_o <= RESET_LEVEL;
		end else begin
			meta <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule // bmc_sync

//--- verilog/bmc_loopback.sv
// bmc_loopback: mii receive path mux with loopback and isolate
// assumes tx nibbles are on clk_i and rx line data already synchronised
`timescale 1ns/1ps
module bmc_loopback (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic en_i,
	// control
	input wire logic loopback_i,
	input wire logic isolate_i,
	input wire logic power_down_i,
	// transmit side from mac
	input wire logic [3:0] txd_i,
	input wire logic tx_en_i,
	// line side receive
	input wire logic [3:0] line_rxd_i,
	input wire logic line_rx_dv_i,
	// receive side to mac
	output logic [3:0] rxd_o,
	output logic rx_dv_o
);
	logic [3:0] next_rxd;
	logic next_rx_dv;

	always_comb begin
		next_rxd = rxd_o;
		next_rx_dv = rx_dv_o;
		if (en_i) begin
			if (isolate_i || power_down_i) begin
				next_rxd = 4'h0;
				next_rx_dv = 1'b0;
			end else if (loopback_i) begin
				next_rxd = txd_i;
				next_rx_dv = tx_en_i;
			end else begin
				next_rxd = line_rxd_i;
				next_rx_dv = line_rx_dv_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rxd_o <= 4'h0;
			rx_dv_o <= 1'b0;
		end else begin
			rxd_o <= next_rxd;
			rx_dv_o <= next_rx_dv;
		end
	end
endmodule // bmc_loopback

//--- verilog/bmc_top.sv
// bmc_top: basic mode control register of a 10/100 transceiver
// assumes a management write/read port on clk_i and asynchronous pins
`timescale 1ns/1ps

// Summary of operation
// - writing reset bit starts soft reset
// - reset bit clears itself when done
// - straps relatched at end of soft reset
// - loopback routes tx nibbles to rx
// - speed bit: one 100, zero 10
// - autoneg on ignores speed and duplex bits
// - autoneg off uses speed and duplex bits
// - power-down bit enters low-power state
// - register access stays alive in power-down
// - power-down is bit OR pin request
// - low pin forces power-down bit set
// - isolate zeroes mii rxd and rx_dv, management still works
// - duplex bit: one full, default strapped
// - restart bit restarts autoneg, self-clears
// - collision test drives collision from tx enable
module bmc_top #(
	parameter int SOFT_RESET_LEN = bmc_pkg::SOFT_RESET_CYCLES,
	parameter int COL_OFF_LEN = bmc_pkg::COL_OFF_CYCLES
) (
	// clock, enable, reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// management register port
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// pins
	input wire logic shared_irq_powerdown_pin_n_i,
	input wire logic strap_duplex_i,
	// auto-negotiation engine
	input wire logic an_started_i,
	output logic an_restart_o,
	// mii
	input wire logic [3:0] txd_i,
	input wire logic tx_en_i,
	input wire logic [3:0] line_rxd_i,
	input wire logic line_rx_dv_i,
	output logic [3:0] rxd_o,
	output logic rx_dv_o,
	output logic col_o,
	// operating mode
	output logic speed_100_o,
	output logic full_duplex_o,
	output logic an_enable_o,
	output logic power_down_o,
	output logic isolate_o,
	output logic soft_reset_o
);
	// ----------------------------------------------------------------
	// parameter check: counters are 16 and 8 bits wide
	// ----------------------------------------------------------------
	if (SOFT_RESET_LEN < 1 || SOFT_RESET_LEN > 65535) begin : g_bad_soft_reset_len
		$error("bmc_top: soft reset length out of range");
	end
	if (COL_OFF_LEN < 1 || COL_OFF_LEN > 255) begin : g_bad_col_off_len
		$error("bmc_top: collision hold length out of range");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic pd_pin_n;
	logic strap_duplex;

	bmc_sync #(.RESET_LEVEL(1'b1)) u_sync_pd (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.en_i(ce_i),
		.async_i(shared_irq_powerdown_pin_n_i),
		.sync_o(pd_pin_n)
	);

	// no reset: strap tracks its pin through reset, so it is valid at release
	bmc_sync #(.RESET_LEVEL(1'b0)) u_sync_strap (
		.clk_i(clk_i),
		.rstn_i(1'b1),
		.en_i(ce_i),
		.async_i(strap_duplex_i),
		.sync_o(strap_duplex)
	);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic [15:0] ctrl;
	logic [15:0] next_ctrl;
	logic [15:0] rst_cnt;
	logic [15:0] next_rst_cnt;
	logic strap_pending;
	logic next_strap_pending;
	logic wr_hit;

	function automatic logic [15:0] defaults(input logic duplex);
		logic [15:0] v;
		v = bmc_pkg::RESET_VALUE;
		v[bmc_pkg::BIT_DUPLEX] = duplex;
		return v;
	endfunction

	function automatic logic addr_hit(input logic [4:0] addr);
		return addr == bmc_pkg::ADDR_BASIC_MODE_CONTROL;
	endfunction

	assign wr_hit = reg_wr_i && addr_hit(reg_addr_i);

	always_comb begin
		next_ctrl = ctrl;
		next_rst_cnt = rst_cnt;
		next_strap_pending = 1'b0;
		if (ce_i) begin
			if (strap_pending) begin
				// strap sampled once synchroniser has settled after reset
				next_ctrl[bmc_pkg::BIT_DUPLEX] = strap_duplex;
			end
			if (ctrl[bmc_pkg::BIT_RESET]) begin
				// register writes held off while soft reset runs
				if (rst_cnt == 16'(SOFT_RESET_LEN - 1)) begin
					next_ctrl = defaults(strap_duplex);
					next_rst_cnt = 16'h0000;
				end else begin
					next_rst_cnt = rst_cnt + 16'h0001;
				end
			end else begin
				// writes accepted even in power-down
				if (wr_hit) begin
					next_ctrl = reg_wdata_i & bmc_pkg::WRITE_MASK;
					if (!reg_wdata_i[bmc_pkg::BIT_AN_ENABLE]) begin
						next_ctrl[bmc_pkg::BIT_AN_RESTART] = 1'b0;
					end
					if (reg_wdata_i[bmc_pkg::BIT_AN_ENABLE] && !reg_wdata_i[bmc_pkg::BIT_AN_RESTART]
						&& ctrl[bmc_pkg::BIT_AN_RESTART]) begin
						next_ctrl[bmc_pkg::BIT_AN_RESTART] = 1'b1;
					end
				end
				if (ctrl[bmc_pkg::BIT_AN_RESTART] && an_started_i) begin
					next_ctrl[bmc_pkg::BIT_AN_RESTART] = 1'b0;
				end
			end
			if (!pd_pin_n) begin
				next_ctrl[bmc_pkg::BIT_POWER_DOWN] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctrl <= bmc_pkg::RESET_VALUE;
			rst_cnt <= 16'h0000;
			strap_pending <= 1'b1;
		end else begin
			ctrl <= next_ctrl;
			rst_cnt <= next_rst_cnt;
			strap_pending <= ce_i ? next_strap_pending : strap_pending;
		end
	end

	// ----------------------------------------------------------------
	// effective power-down request
	// ----------------------------------------------------------------
	logic pd_req;

	// shared by mode output and receive path so both switch together
	assign pd_req = ctrl[bmc_pkg::BIT_POWER_DOWN] | ~pd_pin_n;

	// ----------------------------------------------------------------
	// operating mode outputs
	// ----------------------------------------------------------------
	logic next_speed_100;
	logic next_full_duplex;
	logic next_power_down;
	logic next_an_restart;

	always_comb begin
		next_speed_100 = speed_100_o;
		next_full_duplex = full_duplex_o;
		next_power_down = power_down_o;
		next_an_restart = 1'b0;
		if (ce_i) begin
			if (!ctrl[bmc_pkg::BIT_AN_ENABLE]) begin
				next_speed_100 = ctrl[bmc_pkg::BIT_SPEED];
				next_full_duplex = ctrl[bmc_pkg::BIT_DUPLEX];
			end
			// autoneg on: selection bits are not looked at
			next_power_down = pd_req;
			next_an_restart = ctrl[bmc_pkg::BIT_AN_RESTART] & ctrl[bmc_pkg::BIT_AN_ENABLE];
		end
	end

	// speed/duplex outputs only follow the bits with autoneg off
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			speed_100_o <= 1'b1;
			full_duplex_o <= 1'b0;
			power_down_o <= 1'b0;
			an_restart_o <= 1'b0;
		end else begin
			speed_100_o <= next_speed_100;
			full_duplex_o <= next_full_duplex;
			power_down_o <= next_power_down;
			an_restart_o <= next_an_restart;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [15:0] next_rdata;

	// unmapped addresses read as zero
	always_comb begin
		next_rdata = reg_rdata_o;
		if (ce_i) begin
			next_rdata = addr_hit(reg_addr_i) ? ctrl : 16'h0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// plain copies of control bits
	// ----------------------------------------------------------------
	logic next_an_enable;
	logic next_isolate;
	logic next_soft_reset;

	always_comb begin
		next_an_enable = ce_i ? ctrl[bmc_pkg::BIT_AN_ENABLE] : an_enable_o;
		next_isolate = ce_i ? ctrl[bmc_pkg::BIT_ISOLATE] : isolate_o;
		next_soft_reset = ce_i ? ctrl[bmc_pkg::BIT_RESET] : soft_reset_o;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			an_enable_o <= 1'b1;
			isolate_o <= 1'b0;
			soft_reset_o <= 1'b0;
		end else begin
			an_enable_o <= next_an_enable;
			isolate_o <= next_isolate;
			soft_reset_o <= next_soft_reset;
		end
	end

	// ----------------------------------------------------------------
	// collision test
	// ----------------------------------------------------------------
	logic [7:0] col_cnt;
	logic [7:0] next_col_cnt;
	logic next_col;

	always_comb begin
		next_col = col_o;
		next_col_cnt = col_cnt;
		if (ce_i) begin
			if (ctrl[bmc_pkg::BIT_COL_TEST] && tx_en_i) begin
				next_col = 1'b1;
				next_col_cnt = 8'(COL_OFF_LEN - 1);
			end else if (col_o && col_cnt != 8'h00 && ctrl[bmc_pkg::BIT_COL_TEST]) begin
				next_col_cnt = col_cnt - 8'h01;
			end else begin
				next_col = 1'b0;
				next_col_cnt = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			col_o <= 1'b0;
			col_cnt <= 8'h00;
		end else begin
			col_o <= next_col;
			col_cnt <= next_col_cnt;
		end
	end

	// ----------------------------------------------------------------
	// receive path
	// ----------------------------------------------------------------
	bmc_loopback u_loop (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.en_i(ce_i),
		.loopback_i(ctrl[bmc_pkg::BIT_LOOPBACK]),
		.isolate_i(ctrl[bmc_pkg::BIT_ISOLATE]),
		.power_down_i(pd_req),
		.txd_i(txd_i),
		.tx_en_i(tx_en_i),
		.line_rxd_i(line_rxd_i),
		.line_rx_dv_i(line_rx_dv_i),
		.rxd_o(rxd_o),
		.rx_dv_o(rx_dv_o)
	);
endmodule // bmc_top

//--- tb/bmc_mac_model.sv
// bmc_mac_model: mac-side mii transmitter and autoneg engine stand-in
// assumes the same clock and reset as bmc_top
`timescale 1ns/1ps
module bmc_mac_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// control from bench and phy
	input wire logic send_i,
	input wire logic ack_i,
	input wire logic an_restart_i,
	// drive to phy
	output logic [3:0] txd_o,
	output logic tx_en_o,
	output logic an_started_o
);
	// ----------------------------------------------------------------
	// transmit and negotiation start
	// ----------------------------------------------------------------
	// txd steps by 3 every cycle, so idle data repeats only every 16 cycles
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			txd_o <= 4'h0;
			tx_en_o <= 1'b0;
			an_started_o <= 1'b0;
		end else begin
			txd_o <= txd_o + 4'h3;
			tx_en_o <= send_i;
			an_started_o <= an_restart_i & ack_i;
		end
	end
endmodule // bmc_mac_model

//--- tb/bmc_top_asserts.sv
// bmc_top_asserts: port checker for bmc_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module bmc_top_asserts #(
	parameter int SOFT_RESET_LEN = 3,
	parameter int COL_OFF_LEN = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// register port
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic shared_irq_powerdown_pin_n_i,
	// mii
	input wire logic [3:0] txd_i,
	input wire logic tx_en_i,
	input wire logic [3:0] rxd_o,
	input wire logic rx_dv_o,
	input wire logic col_o,
	// mode
	input wire logic speed_100_o,
	input wire logic an_enable_o,
	input wire logic isolate_o,
	input wire logic power_down_o,
	input wire logic soft_reset_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	localparam int SR_MAX = SOFT_RESET_LEN + 1;
	localparam int COL_MAX = COL_OFF_LEN + 2;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_wr;
		// a write just after a reset request is refused as well
		ce_i && reg_wr_i && reg_addr_i == 5'h00 && !soft_reset_o && !$past(reg_wr_i && reg_wdata_i[15]);
	endsequence
	sequence s_pin_low;
		!shared_irq_powerdown_pin_n_i [*3];
	endsequence
	property p_sr_start;
		s_wr ##0 reg_wdata_i[15] |-> ##2 soft_reset_o;
	endproperty
	a_sr_start: assert property (p_sr_start) else $error("soft reset not started");
	property p_sr_end;
		soft_reset_o |-> ##[1:SR_MAX] !soft_reset_o;
	endproperty
	a_sr_end: assert property (p_sr_end) else $error("soft reset not ended");
	property p_speed;
		s_wr ##0 (!reg_wdata_i[15] && !reg_wdata_i[12]) ##1 ce_i |-> ##1 speed_100_o == $past(reg_wdata_i[13], 2);
	endproperty
	a_speed: assert property (p_speed) else $error("forced speed wrong");
	property p_an_hold;
		an_enable_o && $past(an_enable_o) |-> $stable(speed_100_o);
	endproperty
	a_an_hold: assert property (p_an_hold) else $error("speed moved under autoneg");
	property p_loop;
		$past(reg_addr_i) == 5'h00 && $past(ce_i) && reg_rdata_o[14] && !isolate_o && !power_down_o
			|-> rxd_o == $past(txd_i) && rx_dv_o == $past(tx_en_i);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback data wrong");
	property p_iso;
		isolate_o || power_down_o |-> rxd_o == 4'h0 && !rx_dv_o;
	endproperty
	a_iso: assert property (p_iso) else $error("receive not quiet");
	property p_pin;
		s_pin_low |-> ##[0:3] power_down_o;
	endproperty
	a_pin: assert property (p_pin) else $error("pin power-down missed");
	property p_col_off;
		$fell(tx_en_i) |-> ##[1:COL_MAX] !col_o;
	endproperty
	a_col_off: assert property (p_col_off) else $error("collision stuck");
endmodule // bmc_top_asserts
bind bmc_top bmc_top_asserts #(.SOFT_RESET_LEN(SOFT_RESET_LEN), .COL_OFF_LEN(COL_OFF_LEN)) u_chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.shared_irq_powerdown_pin_n_i(shared_irq_powerdown_pin_n_i), .txd_i(txd_i), .tx_en_i(tx_en_i),
	.rxd_o(rxd_o), .rx_dv_o(rx_dv_o), .col_o(col_o), .speed_100_o(speed_100_o), .an_enable_o(an_enable_o),
	.isolate_o(isolate_o), .power_down_o(power_down_o), .soft_reset_o(soft_reset_o)
);

//--- tb/tb_phy_basic_mode_control.sv
// tb_phy_basic_mode_control: self-checking bench for bmc_top
// assumes bmc_top, the mac model and the checker are compiled
`timescale 1ns/1ps
module tb_phy_basic_mode_control;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] addr = 5'h00;
	logic wr = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic pin_n = 1'b1;
	logic strap = 1'b1;
	logic send = 1'b0;
	logic ack = 1'b1;
	logic ce = 1'b1;
	logic [15:0] rdata, q;
	logic [3:0] txd, rxd;
	logic [4:0] t;
	logic tx_en, rx_dv, col, an_st, an_rs, spd, fdx, ane, pd, iso, srst;
	int num_errors = 0;
	int check_count = 0;
	always #10 clk = ~clk;
	bmc_top #(.SOFT_RESET_LEN(3), .COL_OFF_LEN(2)) uut (.clk_i(clk), .rstn_i(rstn), .ce_i(ce),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.shared_irq_powerdown_pin_n_i(pin_n), .strap_duplex_i(strap), .an_started_i(an_st), .an_restart_o(an_rs),
		.txd_i(txd), .tx_en_i(tx_en), .line_rxd_i(4'ha), .line_rx_dv_i(1'b1), .rxd_o(rxd), .rx_dv_o(rx_dv),
		.col_o(col), .speed_100_o(spd), .full_duplex_o(fdx), .an_enable_o(ane), .power_down_o(pd),
		.isolate_o(iso), .soft_reset_o(srst));
	bmc_mac_model mac (.clk_i(clk), .rstn_i(rstn), .send_i(send), .ack_i(ack), .an_restart_i(an_rs),
		.txd_o(txd), .tx_en_o(tx_en), .an_started_o(an_st));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr_reg(input logic [15:0] d);
		@(posedge clk) wr <= 1'b1;
		wdata <= d;
		addr <= 5'h00;
		@(posedge clk) wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task rd_reg(input logic [4:0] a, output logic [15:0] v);
		@(posedge clk) addr <= a;
		repeat (2) @(posedge clk);
		#1 v = rdata;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		end_of_test;
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(5'h00, q);
		chk(q, 16'h3100);
		chk({spd, ane, pd, iso, srst, an_rs, col}, 7'h60);
		rd_reg(5'h05, q);
		chk(q, 16'h0000);
		$display("done defaults");
		for (int i = 0; i < 4; i++) begin
			wr_reg({2'b00, i[1], 4'h0, i[0], 8'h7f});
			chk({spd, fdx, ane}, {i[1], i[0], 1'b0});
			rd_reg(5'h00, q);
			chk(q, {2'b00, i[1], 4'h0, i[0], 8'h00});
		end
		wr_reg(16'h1000);
		chk({spd, fdx, ane}, 3'h7);
		$display("done modes");
		@(posedge clk) send <= 1'b1;
		wr_reg(16'h4000);
		repeat (4) begin
			t = {tx_en, txd};
			@(posedge clk);
			#1 chk({rx_dv, rxd}, t);
		end
		wr_reg(16'h4400);
		chk({iso, rx_dv, rxd}, 6'h20);
		rd_reg(5'h00, q);
		chk(q, 16'h4400);
		wr_reg(16'h0000);
		chk({rx_dv, rxd}, 5'h1a);
		send <= 1'b0;
		$display("done loopback");
		wr_reg(16'h0800);
		chk({pd, rx_dv, rxd}, 6'h20);
		rd_reg(5'h00, q);
		chk(q, 16'h0800);
		wr_reg(16'h0000);
		chk(pd, 1'b0);
		@(posedge clk) pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1 chk(pd, 1'b1);
		@(posedge clk) pin_n <= 1'b1;
		rd_reg(5'h00, q);
		chk(q, 16'h0800);
		wr_reg(16'h0000);
		$display("done power-down");
		ack <= 1'b0;
		wr_reg(16'h1200);
		chk(an_rs, 1'b1);
		rd_reg(5'h00, q);
		chk(q, 16'h1200);
		ack <= 1'b1;
		rd_reg(5'h00, q);
		chk({an_rs, q}, 17'h01000);
		wr_reg(16'h0200);
		chk(an_rs, 1'b0);
		$display("done restart");
		wr_reg(16'h0080);
		@(posedge clk) send <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(col, 1'b1);
		@(posedge clk) send <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk(col, 1'b0);
		$display("done collision");
		wr_reg(16'h2100);
		@(posedge clk) strap <= 1'b0;
		@(posedge clk) wr <= 1'b1;
		wdata <= 16'h8000;
		@(posedge clk) wdata <= 16'h0400;
		@(posedge clk) wr <= 1'b0;
		#1 chk(rdata[15], 1'b1);
		repeat (10) @(posedge clk);
		rd_reg(5'h00, q);
		chk({srst, q}, 17'h03000);
		$display("done soft reset");
		@(posedge clk) ce <= 1'b0;
		wr_reg(16'h0100);
		chk({ane, fdx}, 2'h2);
		@(posedge clk) ce <= 1'b1;
		rd_reg(5'h00, q);
		chk(q, 16'h3000);
		$display("done clock enable");
		end_of_test;
	end
endmodule // tb_phy_basic_mode_control
